// ==== rtl/pfcd_pkg.sv ====
// Purpose: constants for the parallel flash command host
// Assumes: 8-bit data bus, 19 address pins, 10 MHz system clock
// Notes: command codes and unlock addresses of the flash command set
package pfcd_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam logic [18:0] UNLOCK_ADDR_1 = 19'h0_0555;
   localparam logic [18:0] UNLOCK_ADDR_2 = 19'h0_02AA;
   localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
   localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [18:0] ID_MAKER_ADDR = 19'h0_0000;
   localparam logic [18:0] ID_PART_ADDR = 19'h0_0001;
   localparam logic [18:0] ID_PROTECT_OFS = 19'h0_0002;
   localparam int SECTOR_LSB = 16;
   // bus timing in ns, converted to whole 100 ns cycles (rounded up)
   localparam int CLK_NS = 100;
   localparam int SETUP_NS = 100;
   localparam int STROBE_NS = 200;
   localparam int ACCESS_NS = 200;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {
      PFCD_OP_READ,
      PFCD_OP_ID_READ,
      PFCD_OP_PROGRAM,
      PFCD_OP_CHIP_ERASE,
      PFCD_OP_SECTOR_ERASE,
      PFCD_OP_SUSPEND,
      PFCD_OP_RESUME,
      PFCD_OP_RESET
   } pfcd_op_type;
endpackage

// ==== rtl/pfcd_cycle_if.sv ====
// Purpose: one bus cycle request between sequencer and cycle engine
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface pfcd_cycle_if;
   import pfcd_pkg::*;
   logic start;
   logic is_write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;
   modport seq (output start, is_write, addr, wdata, input done, rdata);
   modport eng (input start, is_write, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ==== rtl/pfcd_cycle_engine.sv ====
// Purpose: drives one read or write cycle on the flash pins
// Assumes: pin inputs arrive already synchronised
// Notes: write holds address before strobe fall, data through its rise
`timescale 1ns/10ps
`default_nettype none
module pfcd_cycle_engine
   import pfcd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request side
   pfcd_cycle_if.eng req,
   // pin side
   input wire logic [pfcd_pkg::DATA_W-1:0] data_sync,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_n,
   output logic [pfcd_pkg::ADDR_W-1:0] addr_pins,
   output logic [pfcd_pkg::DATA_W-1:0] data_out,
   output logic data_oe
);
   import pfcd_pkg::*;
   typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD, DONE} pfcd_eng_type;
   pfcd_eng_type state;
   logic [3:0] count;
   logic is_wr;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
         count <= 4'h0;
         is_wr <= 1'b0;
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_n <= 1'b1;
         addr_pins <= '0;
         data_out <= '0;
         data_oe <= 1'b0;
         req.done <= 1'b0;
         req.rdata <= '0;
      end else begin
         req.done <= 1'b0;
         case (state)
            IDLE: begin
               if (req.start) begin
                  is_wr <= req.is_write;
                  addr_pins <= req.addr;
                  data_out <= req.wdata;
                  chip_sel_n <= 1'b0;
                  count <= 4'(SETUP_CYC);
                  state <= SETUP;
               end
            end
            SETUP: begin
               if (count > 4'h1) begin
                  count <= count - 4'h1;
               end else begin
                  // write: ce low, oe high, we low
                  // read: ce and oe low, we high
                  write_n <= !is_wr;
                  out_en_n <= is_wr;
                  data_oe <= is_wr;
                  count <= is_wr ? 4'(STROBE_CYC) : 4'(ACCESS_CYC + 2);
                  state <= STROBE;
               end
            end
            STROBE: begin
               if (count > 4'h1) begin
                  count <= count - 4'h1;
               end else begin
                  // data latched by the device on this rising strobe
                  req.rdata <= data_sync;
                  write_n <= 1'b1;
                  out_en_n <= 1'b1;
                  state <= HOLD;
               end
            end
            HOLD: begin
               chip_sel_n <= 1'b1;
               data_oe <= 1'b0;
               state <= DONE;
            end
            DONE: begin
               req.done <= 1'b1;
               state <= IDLE;
            end
            default: state <= IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== rtl/pfcd_host.sv ====
// Purpose: host controller issuing flash command sequences on the pins
// Assumes: one operation at a time; caller polls status by plain reads
// Notes: pins are three-signal; data_oe high while driving the data bus
// Contract
// - unlock, 90h, enters identifier mode
// - program: unlocks, A0h, then address and byte
// - chip erase: six writes ending 10h
// - sector erase: six writes, 30h at sector
// - F0h anywhere returns to array read
// - read: ce, oe low, we high
// - after failure host writes F0h to abort; the host detects no failure itself and writes F0h only for a PFCD_OP_RESET op
// - identifier mode held until reset command
`timescale 1ns/10ps
`default_nettype none
module pfcd_host
   import pfcd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // user command port
   input wire logic op_valid,
   input wire pfcd_pkg::pfcd_op_type op_code,
   input wire logic [pfcd_pkg::ADDR_W-1:0] op_addr,
   input wire logic [pfcd_pkg::DATA_W-1:0] op_data,
   output logic op_ready,
   output logic op_done,
   output logic [pfcd_pkg::DATA_W-1:0] op_rdata,
   output logic id_mode,
   // flash pins
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_n,
   output logic [pfcd_pkg::ADDR_W-1:0] address_pins,
   input wire logic [pfcd_pkg::DATA_W-1:0] data_pins_in,
   output logic [pfcd_pkg::DATA_W-1:0] data_pins_out,
   output logic data_pins_oe
);
   import pfcd_pkg::*;

   // ****************************************
   // reset release and pin synchroniser
   // ****************************************
   logic rst_meta, rst_n;
   logic [DATA_W-1:0] data_meta, data_sync;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_meta <= '0;
         data_sync <= '0;
      end else begin
         data_meta <= data_pins_in;
         data_sync <= data_meta;
      end
   end

   // ****************************************
   // cycle engine
   // ****************************************
   pfcd_cycle_if cyc ();
   pfcd_cycle_engine u_engine (
      .clk(sys_clk),
      .rst_n(rst_n),
      .req(cyc),
      .data_sync(data_sync),
      .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n),
      .write_n(write_n),
      .addr_pins(address_pins),
      .data_out(data_pins_out),
      .data_oe(data_pins_oe)
   );

   // ****************************************
   // command sequencer
   // ****************************************
   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} pfcd_seq_type;
   pfcd_seq_type state;
   pfcd_op_type op;
   logic [ADDR_W-1:0] tgt_addr;
   logic [DATA_W-1:0] tgt_data;
   logic [2:0] step;
   logic [2:0] last_step;
   logic [ADDR_W-1:0] step_addr;
   logic [DATA_W-1:0] step_data;
   logic step_write;

   // length of each sequence, in bus cycles minus one
   function automatic logic [2:0] seq_len(input pfcd_op_type o);
      case (o)
         PFCD_OP_ID_READ: seq_len = 3'd3; // unlock, 90h, then one id read
         PFCD_OP_PROGRAM: seq_len = 3'd3;
         PFCD_OP_CHIP_ERASE: seq_len = 3'd5;
         PFCD_OP_SECTOR_ERASE: seq_len = 3'd5;
         default: seq_len = 3'd0;
      endcase
   endfunction

   // address and data of each step; unlock prefix shared by all long ops
   always_comb begin
      step_write = 1'b1;
      step_addr = UNLOCK_ADDR_1;
      step_data = UNLOCK_DATA_1;
      case (op)
         PFCD_OP_READ: begin
            // plain read; returns identifier data while in identifier mode
            step_write = 1'b0;
            step_addr = tgt_addr;
         end
         PFCD_OP_RESET: step_data = CMD_RESET;
         PFCD_OP_SUSPEND: step_data = CMD_SUSPEND;
         PFCD_OP_RESUME: step_data = CMD_RESUME;
         default: begin
            case (step)
               3'd0, 3'd3: begin
                  step_addr = UNLOCK_ADDR_1;
                  step_data = UNLOCK_DATA_1;
               end
               3'd1, 3'd4: begin
                  step_addr = UNLOCK_ADDR_2;
                  step_data = UNLOCK_DATA_2;
               end
               default: step_addr = UNLOCK_ADDR_1;
            endcase
            if (step == 3'd2) begin
               case (op)
                  PFCD_OP_ID_READ: step_data = CMD_IDENT;
                  PFCD_OP_PROGRAM: step_data = CMD_PROGRAM;
                  default: step_data = CMD_ERASE_SETUP;
               endcase
            end
            if (op == PFCD_OP_ID_READ && step == 3'd3) begin
               // id offsets: 0 maker, 1 part, 2 protect at sector
               step_write = 1'b0;
               step_addr = tgt_addr;
            end
            if (op == PFCD_OP_PROGRAM && step == 3'd3) begin
               step_addr = tgt_addr;
               step_data = tgt_data;
            end
            if (op == PFCD_OP_CHIP_ERASE && step == 3'd5) begin
               step_data = CMD_CHIP_ERASE;
            end
            if (op == PFCD_OP_SECTOR_ERASE && step == 3'd5) begin
               // any address in the sector, upper bits select it
               step_addr = tgt_addr;
               step_data = CMD_SECTOR_ERASE;
            end
         end
      endcase
   end

   assign cyc.is_write = step_write;
   assign cyc.addr = step_addr;
   assign cyc.wdata = step_data;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         op <= PFCD_OP_READ;
         tgt_addr <= '0;
         tgt_data <= '0;
         step <= 3'd0;
         last_step <= 3'd0;
         cyc.start <= 1'b0;
         op_ready <= 1'b0;
         op_done <= 1'b0;
         op_rdata <= '0;
      end else begin
         cyc.start <= 1'b0;
         op_done <= 1'b0;
         case (state)
            S_IDLE: begin
               op_ready <= 1'b1;
               if (op_valid && op_ready) begin
                  op <= op_code;
                  tgt_addr <= op_addr;
                  tgt_data <= op_data;
                  step <= 3'd0;
                  last_step <= seq_len(op_code);
                  op_ready <= 1'b0;
                  state <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               cyc.start <= 1'b1;
               state <= S_WAIT;
            end
            S_WAIT: begin
               if (cyc.done) begin
                  if (step == last_step) begin
                     op_rdata <= cyc.rdata;
                     op_done <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     step <= step + 3'd1;
                     state <= S_ISSUE;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // identifier mode tracking
   // ****************************************
   // mirrors the device: set by id sequence, held until F0h
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         id_mode <= 1'b0; // device starts in array read
      end else if (op_done) begin
         if (op == PFCD_OP_ID_READ) begin
            id_mode <= 1'b1;
         end else if (op == PFCD_OP_RESET) begin
            id_mode <= 1'b0; // also the abort after a failure
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/pfcd_host_asserts.sv ====
// Purpose: pin and handshake checks for the flash command host
// Assumes: one clock domain, reset_n active low
// Notes: bound to pfcd_host at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module pfcd_host_asserts
   import pfcd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // user side
   input wire logic op_valid,
   input wire pfcd_pkg::pfcd_op_type op_code,
   input wire logic op_ready,
   input wire logic op_done,
   // flash pins
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic [pfcd_pkg::ADDR_W-1:0] address_pins,
   input wire logic [pfcd_pkg::DATA_W-1:0] data_pins_out,
   input wire logic data_pins_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   AST_WR_STROBES: assert property (!write_n |-> !chip_sel_n && out_en_n)
      else $error("write strobe outside a selected write cycle");
   AST_RD_STROBES: assert property (!out_en_n |-> write_n && !data_pins_oe)
      else $error("output enable while writing or driving data");
   AST_DESELECT_FLOAT: assert property (chip_sel_n |-> !data_pins_oe)
      else $error("data driven while deselected");
   AST_IDLE_PINS: assert property (op_ready |-> chip_sel_n && out_en_n && write_n)
      else $error("strobes active while idle");
   AST_ADDR_HOLD: assert property (!write_n |-> $stable(address_pins) && $stable(data_pins_out))
      else $error("address or data moved under write strobe");
   AST_STROBE_WIDTH: assert property ($fell(write_n) |=> !write_n ##1 write_n)
      else $error("write strobe width wrong");
   AST_DONE_PULSE: assert property (op_done |=> !op_done)
      else $error("done longer than one cycle");
   AST_TAKE: assert property (op_valid && op_ready |=> !op_ready)
      else $error("ready held after acceptance");
   AST_RESET_LEN: assert property (op_valid && op_ready && op_code == PFCD_OP_RESET
      |-> ##[8:10] op_done)
      else $error("single write op did not finish in time");
   cover property (op_valid && op_ready && op_code == PFCD_OP_ID_READ);
   cover property (op_valid && op_ready && op_code == PFCD_OP_PROGRAM);
   cover property (op_valid && op_ready && op_code == PFCD_OP_SECTOR_ERASE);
endmodule
bind pfcd_host pfcd_host_asserts u_asserts (.sys_clk, .reset_n, .op_valid, .op_code,
   .op_ready, .op_done, .chip_sel_n, .out_en_n, .write_n, .address_pins, .data_pins_out,
   .data_pins_oe);
`default_nettype wire

// ==== test/pfcd_flash_model.sv ====
// Purpose: behavioural parallel flash answering the host pins
// Assumes: program and chip erase finish at once
// Notes: status polling bits are not modelled
`timescale 1ns/10ps
`default_nettype none
module pfcd_flash_model
   import pfcd_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] PROT_MASK = 8'h02,
   parameter int ERASE_NS = 3000
)
(
   // pins
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic [pfcd_pkg::ADDR_W-1:0] address_pins,
   input wire logic [pfcd_pkg::DATA_W-1:0] bus_in,
   output logic [pfcd_pkg::DATA_W-1:0] bus_out
);
   import pfcd_pkg::*;
   logic [7:0] mem [0:524287];
   logic [18:0] wa;
   logic [7:0] last = 8'h00;
   logic id_md = 0;
   logic erasing = 0;
   logic susp = 0;
   int step = 0;
   initial foreach (mem[k]) mem[k] = 8'hFF;
   function automatic logic [7:0] rd(input logic [18:0] a);
      if (!id_md) return mem[a];
      case (a[1:0])
         2'd0: return MAKER_CODE;
         2'd1: return PART_CODE;
         2'd2: return {7'h00, PROT_MASK[a[18:16]]};
         default: return 8'h00;
      endcase
   endfunction
   // released bus shows the inverse so a stale value never passes
   always @* begin
      if (!chip_sel_n && !out_en_n && write_n) begin
         bus_out = rd(address_pins);
         last = bus_out;
      end else bus_out = ~last;
   end
   always @(negedge write_n) if (!chip_sel_n) wa = address_pins;
   always @(posedge write_n) begin
      if (!chip_sel_n && out_en_n) begin
         if (erasing) begin
            if (bus_in == CMD_SUSPEND) susp = 1;
            else if (bus_in == CMD_RESUME) susp = 0;
         end else if (bus_in == CMD_RESET) begin
            step = 0;
            id_md = 0;
         end else case (step)
            0: step = (wa == UNLOCK_ADDR_1 && bus_in == UNLOCK_DATA_1) ? 1 : 0;
            1: step = (wa == UNLOCK_ADDR_2 && bus_in == UNLOCK_DATA_2) ? 2 : 0;
            2: begin
               step = 0;
               if (wa == UNLOCK_ADDR_1 && bus_in == CMD_IDENT) id_md = 1;
               if (wa == UNLOCK_ADDR_1 && bus_in == CMD_PROGRAM) step = 3;
               if (wa == UNLOCK_ADDR_1 && bus_in == CMD_ERASE_SETUP) step = 4;
            end
            3: begin
               mem[wa] = mem[wa] & bus_in;
               step = 0;
            end
            4: step = (wa == UNLOCK_ADDR_1 && bus_in == UNLOCK_DATA_1) ? 5 : 0;
            5: step = (wa == UNLOCK_ADDR_2 && bus_in == UNLOCK_DATA_2) ? 6 : 0;
            6: begin
               step = 0;
               if (wa == UNLOCK_ADDR_1 && bus_in == CMD_CHIP_ERASE)
                  foreach (mem[k]) mem[k] = 8'hFF;
               if (bus_in == CMD_SECTOR_ERASE) begin
                  for (int k = 0; k < 65536; k++) mem[{wa[18:16], k[15:0]}] = 8'hFF;
                  erasing = 1;
                  fork
                     begin
                        #(ERASE_NS);
                        wait (!susp);
                        erasing = 0;
                     end
                  join_none
               end
            end
            default: step = 0;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== test/parallel_flash_command_decoder_tb.sv ====
// Purpose: self-checking bench for the flash command host
// Assumes: behavioural flash model on the pins
// Notes: inputs change on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module parallel_flash_command_decoder_tb;
   import pfcd_pkg::*;
   `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
      $display("Error t=%0t got %h exp %h", $time, g, e); end end
   typedef struct {pfcd_op_type op; logic [18:0] a; logic [7:0] d; logic [7:0] e; bit c;}
      pfcd_row_type;
   logic sys_clk, reset_n, op_valid, op_ready, op_done, id_mode;
   logic chip_sel_n, out_en_n, write_n, data_pins_oe;
   pfcd_op_type op_code;
   logic [18:0] op_addr, address_pins;
   logic [7:0] op_data, op_rdata, data_pins_out, dev_q, bus, got;
   int num_errors = 0;
   int checks_done = 0;
   pfcd_row_type rows [13] = '{
      '{PFCD_OP_READ, 19'h0_0100, 8'h00, 8'hFF, 1}, '{PFCD_OP_PROGRAM, 19'h0_0100, 8'h3C, 8'h00, 0},
      '{PFCD_OP_READ, 19'h0_0100, 8'h00, 8'h3C, 1}, '{PFCD_OP_PROGRAM, 19'h1_0200, 8'hC3, 8'h00, 0},
      '{PFCD_OP_ID_READ, 19'h0_0000, 8'h00, 8'h5A, 1}, '{PFCD_OP_READ, 19'h0_0001, 8'h00, 8'hA5, 1},
      '{PFCD_OP_READ, 19'h1_0002, 8'h00, 8'h01, 1}, '{PFCD_OP_READ, 19'h0_0002, 8'h00, 8'h00, 1},
      '{PFCD_OP_READ, 19'h0_0007, 8'h00, 8'h00, 1}, '{PFCD_OP_RESET, 19'h0_0000, 8'h00, 8'h00, 0},
      '{PFCD_OP_READ, 19'h0_0100, 8'h00, 8'h3C, 1}, '{PFCD_OP_CHIP_ERASE, 19'h0_0000, 8'h00, 8'h00, 0},
      '{PFCD_OP_READ, 19'h1_0200, 8'h00, 8'hFF, 1}};
   assign bus = data_pins_oe ? data_pins_out : dev_q;
   pfcd_host dut (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid),
      .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_ready(op_ready),
      .op_done(op_done), .op_rdata(op_rdata), .id_mode(id_mode), .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n), .write_n(write_n), .address_pins(address_pins),
      .data_pins_in(bus), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
   pfcd_flash_model flash (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
      .address_pins(address_pins), .bus_in(bus), .bus_out(dev_q));
   initial begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_op(input pfcd_op_type op, input logic [18:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (op_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 50) num_errors++;
      op_valid = 1'b1;
      op_code = op;
      op_addr = a;
      op_data = d;
      @(negedge sys_clk);
      op_valid = 0;
      n = 0;
      while (op_done !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 200) num_errors++;
      got = op_rdata;
   endtask
   initial begin
      #3_000_000;
      num_errors++;
      finish_test();
   end
   initial begin
      reset_n = 1'b0;
      op_valid = 1'b0;
      op_code = PFCD_OP_READ;
      op_addr = '0;
      op_data = '0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1;
      foreach (rows[i]) begin
         do_op(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].c) `CHK(got, rows[i].e)
         $display("row %0d done", i);
      end
      do_op(PFCD_OP_ID_READ, 19'h0_0001, 8'h00);
      `CHK(got, 8'hA5)
      // id_mode follows op_done by one clock
      @(negedge sys_clk);
      `CHK(id_mode, 1'b1)
      do_op(PFCD_OP_RESET, 19'h0_0000, 8'h00);
      @(negedge sys_clk);
      `CHK(id_mode, 1'b0)
      $display("id mode test done");
      do_op(PFCD_OP_PROGRAM, 19'h0_0100, 8'h3C);
      do_op(PFCD_OP_PROGRAM, 19'h1_0200, 8'hC3);
      do_op(PFCD_OP_SECTOR_ERASE, 19'h1_0000, 8'h00);
      do_op(PFCD_OP_PROGRAM, 19'h2_0000, 8'h5A);
      do_op(PFCD_OP_SUSPEND, 19'h0_0000, 8'h00);
      do_op(PFCD_OP_RESUME, 19'h0_0000, 8'h00);
      // outlasts the model's erase time, stays on the falling edge
      repeat (40) @(negedge sys_clk);
      do_op(PFCD_OP_READ, 19'h1_0200, 8'h00);
      `CHK(got, 8'hFF)
      do_op(PFCD_OP_READ, 19'h0_0100, 8'h00);
      `CHK(got, 8'h3C)
      do_op(PFCD_OP_READ, 19'h2_0000, 8'h00);
      `CHK(got, 8'hFF)
      $display("sector erase test done");
      @(negedge sys_clk);
      op_valid = 1'b1;
      op_code = PFCD_OP_PROGRAM;
      repeat (4) @(negedge sys_clk);
      {op_valid, reset_n} = 2'b00;
      #10;
      `CHK({chip_sel_n, write_n, op_ready, id_mode, data_pins_oe}, 5'b11000)
      repeat (3) @(negedge sys_clk);
      reset_n = 1;
      repeat (5) @(negedge sys_clk);
      `CHK(op_ready, 1'b1)
      do_op(PFCD_OP_READ, 19'h0_0100, 8'h00);
      `CHK(got, 8'h3C)
      $display("reset test done");
      finish_test();
   end
endmodule
`default_nettype wire
